// File: design/dsl_pkg.sv
// Contract
// - Shift one bit per serial clock rise
// - Word arrives MSB first, selector last
// - Load strobe rise copies word to one latch
// - Destination chosen by shift bits one, zero
// - 00 IF ref, 01 IF AB, 10 RF ref, 11 RF AB
// - Ref latch: divide, polarity, gain, tristate, selects
// - Reference divider per channel, ratios 1..16383 (base), 1..32767 (wide)
// - Base: 6-bit swallow, 11-bit main counter
// - Wide: 5-bit swallow, 13-bit main counter
// - Phase comparator drives correction pulses
// - Status output source from four select bits
// - Lock detect: open-drain, high with low pulses
// - Tristate set: power-down at load edge
// - Tristate clear: tristate pump, then power-down
package dsl_pkg;

    // ----------------------------------------
    // Word and latch layout
    // ----------------------------------------
    localparam int WORD_W = 22;
    localparam int REF_LSB = 2;
    localparam int REF_MSB = 15;
    localparam int EXTRA_DIV_BIT = 16;
    localparam int POL_BIT = 17;
    localparam int GAIN_BIT = 18;
    localparam int TRI_BIT = 19;
    localparam int SEL_LO_BIT = 20;
    localparam int SEL_HI_BIT = 21;
    localparam int PRE_BIT = 20;
    localparam int PD_BIT = 21;
    localparam int SWALLOW_LSB = 2;
    localparam int MAIN_MSB = 19;
    localparam logic [WORD_W-1:0] LATCH_RESET = 22'h000000;

    // Selector codes
    localparam logic [1:0] SEL_IF_REF = 2'h0;
    localparam logic [1:0] SEL_IF_AB = 2'h1;
    localparam logic [1:0] SEL_RF_REF = 2'h2;
    localparam logic [1:0] SEL_RF_AB = 2'h3;

    // Status output sources, {rf_hi, rf_lo, if_hi, if_lo}
    localparam logic [3:0] MUX_LOW = 4'h0;
    localparam logic [3:0] MUX_IF_LOCK = 4'h1;
    localparam logic [3:0] MUX_IF_REF = 4'h2;
    localparam logic [3:0] MUX_IF_N = 4'h3;
    localparam logic [3:0] MUX_RF_LOCK = 4'h4;
    localparam logic [3:0] MUX_BOTH_LOCK = 4'h5;
    localparam logic [3:0] MUX_RF_REF = 4'h8;
    localparam logic [3:0] MUX_RF_N = 4'h9;

    // Lock detect timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_ERR_NS = 30;
    localparam int LOCK_ERR_CYCLES = LOCK_ERR_NS / CLK_PERIOD_NS;
    localparam logic [7:0] LOCK_ERR_LIMIT = 8'(LOCK_ERR_CYCLES);
    localparam logic [7:0] LOCK_GOOD_COMPARES = 8'h0f;

    // Per channel settings taken from the latches
    typedef struct packed {
        logic [14:0] ref_div;
        logic polarity;
        logic pump_gain;
        logic pump_tristate;
        logic out_select_low;
        logic out_select_high;
        logic [12:0] main_count;
        logic [5:0] swallow_count;
        logic prescaler_select;
        logic powerdown_bit;
    } dsl_chan_cfg_type;

endpackage

// File: design/dsl_serial_latch_bank.sv
`timescale 1ns/1ps
module dsl_serial_latch_bank
    import dsl_pkg::*;
#(
    parameter int WIDE_DIV = 0
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic ref_clock_in,
    input wire logic [1:0] feedback_in,
    output dsl_chan_cfg_type [1:0] chan_cfg,
    output logic [1:0] modulus_control,
    output logic [1:0] pump_up,
    output logic [1:0] pump_down,
    output logic [1:0] pump_tristate,
    output logic [1:0] powered_down,
    output logic multiplexed_status_output,
    output logic multiplexed_status_output_oe
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (WIDE_DIV != 0 && WIDE_DIV != 1)
    begin : bad_wide_div
        $error("WIDE_DIV must be 0 or 1");
    end

    // ----------------------------------------
    // Pin synchronisers and edge finders
    // ----------------------------------------
    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_prev;
    logic [NPIN-1:0] pin_rise;

    assign pin_raw = {feedback_in, ref_clock_in, load_strobe, serial_data, serial_clock};

    // Two flops per pin, then one for edge finding
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_prev <= '0;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    assign pin_rise = pin_s2 & ~pin_prev;

    logic sclk_rise;
    logic sdata;
    logic le_rise;
    logic ref_rise;
    logic [1:0] fb_rise;

    assign sclk_rise = pin_rise[0];
    assign sdata = pin_s2[1];
    assign le_rise = pin_rise[2];
    assign ref_rise = pin_rise[3];
    assign fb_rise = pin_rise[5:4];

    // ----------------------------------------
    // Input shift register
    // ----------------------------------------
    logic [WORD_W-1:0] shift_word;

    // New bit enters at bit zero, so the last two land lowest
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            shift_word <= '0;
        else if (sclk_rise)
            shift_word <= {shift_word[WORD_W-2:0], sdata};
    end

    // ----------------------------------------
    // Latch bank
    // ----------------------------------------
    logic [1:0] word_sel;
    logic [3:0] latch_hit;
    logic [WORD_W-1:0] latch [4];

    assign word_sel = shift_word[1:0];
    assign latch_hit = le_rise ? (4'h1 << word_sel) : 4'h0;

    for (genvar i = 0; i < 4; i++)
    begin : lat
        // Whole word copied on a selected strobe rise
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
                latch[i] <= LATCH_RESET;
            else if (latch_hit[i])
                latch[i] <= shift_word;
        end
    end

    // ----------------------------------------
    // Synthesizer channels, 0 is IF, 1 is RF
    // ----------------------------------------
    for (genvar c = 0; c < 2; c++)
    begin : ch
        logic [WORD_W-1:0] rl;
        logic [WORD_W-1:0] al;
        logic [14:0] r_val;
        logic [12:0] b_val;
        logic [5:0] a_val;
        logic hold;
        logic [14:0] rcnt;
        logic [12:0] bcnt;
        logic [5:0] acnt;
        logic ref_evt;
        logic n_evt;
        logic up;
        logic dn;
        logic a_in;
        logic b_in;
        logic both;
        logic [7:0] err_cnt;
        logic [7:0] good_cnt;
        logic locked;
        logic lock_ind;
        logic pd_q;
        logic pd_pend;
        logic pd_load;

        assign rl = latch[2*c];
        assign al = latch[2*c+1];

        // Divide fields per variant
        assign r_val = (WIDE_DIV == 1) ? rl[EXTRA_DIV_BIT:REF_LSB]
            : {1'b0, rl[REF_MSB:REF_LSB]};
        assign b_val = (WIDE_DIV == 1) ? al[MAIN_MSB:7]
            : {2'h0, al[MAIN_MSB:9]};
        assign a_val = (WIDE_DIV == 1) ? {1'b0, al[6:SWALLOW_LSB]}
            : al[7:SWALLOW_LSB];

        assign chan_cfg[c] = '{ref_div: r_val, polarity: rl[POL_BIT],
            pump_gain: rl[GAIN_BIT], pump_tristate: rl[TRI_BIT],
            out_select_low: rl[SEL_LO_BIT], out_select_high: rl[SEL_HI_BIT],
            main_count: b_val, swallow_count: a_val,
            prescaler_select: al[PRE_BIT], powerdown_bit: al[PD_BIT]};

        assign hold = pd_q;

        // Reference divider, ratio 0 acts as 1
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                rcnt <= 15'h0001;
                ref_evt <= 1'b0;
            end
            else
            begin
                ref_evt <= 1'b0;
                if (hold)
                    rcnt <= r_val;
                else if (ref_rise && rcnt <= 15'h0001)
                begin
                    rcnt <= r_val;
                    ref_evt <= 1'b1;
                end
                else if (ref_rise)
                    rcnt <= rcnt - 15'h0001;
            end
        end

        // Feedback divider: swallow then main count of prescaler edges
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                bcnt <= 13'h0001;
                acnt <= 6'h00;
                n_evt <= 1'b0;
            end
            else
            begin
                n_evt <= 1'b0;
                if (hold)
                begin
                    bcnt <= b_val;
                    acnt <= a_val;
                end
                else if (fb_rise[c] && bcnt <= 13'h0001)
                begin
                    bcnt <= b_val;
                    acnt <= a_val;
                    n_evt <= 1'b1;
                end
                else if (fb_rise[c])
                begin
                    bcnt <= bcnt - 13'h0001;
                    if (acnt != 6'h00)
                        acnt <= acnt - 6'h01;
                end
            end
        end

        assign modulus_control[c] = (acnt != 6'h00) && !hold;

        // Phase comparator flops, cleared when both have fired
        assign a_in = up | ref_evt;
        assign b_in = dn | n_evt;
        assign both = a_in & b_in;

        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                up <= 1'b0;
                dn <= 1'b0;
            end
            else
            begin
                up <= a_in & ~both & ~hold;
                dn <= b_in & ~both & ~hold;
            end
        end

        // Pump drive with polarity swap and three-state
        assign pump_tristate[c] = rl[TRI_BIT] | pd_pend | pd_q;
        assign pump_up[c] = ~pump_tristate[c] & (rl[POL_BIT] ? up : dn);
        assign pump_down[c] = ~pump_tristate[c] & (rl[POL_BIT] ? dn : up);

        // Lock detect: enough short-error compares in a row
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                err_cnt <= 8'h00;
                good_cnt <= 8'h00;
            end
            else
            begin
                // Saturates at the limit so a long pulse never wraps back to zero
                err_cnt <= (up | dn) ? err_cnt + {7'h00, err_cnt < LOCK_ERR_LIMIT} : 8'h00;
                if (hold || err_cnt >= LOCK_ERR_LIMIT)
                    good_cnt <= 8'h00;
                else if (ref_evt && good_cnt != LOCK_GOOD_COMPARES)
                    good_cnt <= good_cnt + 8'h01;
            end
        end

        assign locked = (good_cnt == LOCK_GOOD_COMPARES);
        assign lock_ind = locked & ~(up | dn);

        // Power-down sequencing
        assign pd_load = latch_hit[2*c+1] & shift_word[PD_BIT];

        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                pd_q <= 1'b0;
                pd_pend <= 1'b0;
            end
            else if (latch_hit[2*c+1] && !shift_word[PD_BIT])
            begin
                pd_q <= 1'b0;
                pd_pend <= 1'b0;
            end
            else if (pd_load && rl[TRI_BIT])
                pd_q <= 1'b1;
            else if (pd_load)
                pd_pend <= 1'b1;
            else if (pd_pend && !up && !dn)
            begin
                pd_pend <= 1'b0;
                pd_q <= 1'b1;
            end
        end

        assign powered_down[c] = pd_q;
    end

    // ----------------------------------------
    // Multiplexed status output
    // ----------------------------------------
    logic [3:0] mux_sel;
    logic next_mux_level;
    logic next_mux_od;
    logic mux_level;
    logic mux_od;

    assign mux_sel = {latch[2][SEL_HI_BIT], latch[2][SEL_LO_BIT],
        latch[0][SEL_HI_BIT], latch[0][SEL_LO_BIT]};

    // Source selection
    always_comb
    begin
        next_mux_od = 1'b0;
        unique case (mux_sel)
            MUX_IF_LOCK:
            begin
                next_mux_level = ch[0].lock_ind;
                next_mux_od = 1'b1;
            end
            MUX_RF_LOCK:
            begin
                next_mux_level = ch[1].lock_ind;
                next_mux_od = 1'b1;
            end
            MUX_BOTH_LOCK:
            begin
                next_mux_level = ch[0].lock_ind & ch[1].lock_ind;
                next_mux_od = 1'b1;
            end
            MUX_IF_REF: next_mux_level = ch[0].ref_evt;
            MUX_IF_N: next_mux_level = ch[0].n_evt;
            MUX_RF_REF: next_mux_level = ch[1].ref_evt;
            MUX_RF_N: next_mux_level = ch[1].n_evt;
            default: next_mux_level = 1'b0;
        endcase
    end

    // Registered output level and drive mode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mux_level <= 1'b0;
            mux_od <= 1'b0;
        end
        else
        begin
            mux_level <= next_mux_level;
            mux_od <= next_mux_od;
        end
    end

    // Open-drain only pulls low; pull-up gives the high
    assign multiplexed_status_output = mux_od ? 1'b0 : mux_level;
    assign multiplexed_status_output_oe = mux_od ? ~mux_level : 1'b1;

endmodule // dsl_serial_latch_bank

// File: test/dsl_host_model.sv
`timescale 1ns/1ps
module dsl_host_model
(
    output logic serial_clock,
    output logic serial_data,
    output logic load_strobe
);
    // Idle link, clock still
    initial
    begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    // One word at 125 ns a bit, then strobe
    task automatic send(input logic [21:0] w);
        #1.25; // Keeps every pin edge off both clock edges
        for (int i = 21; i >= 0; i--)
        begin
            serial_data = w[i];
            #62.5 serial_clock = 1'b1;
            #62.5 serial_clock = 1'b0;
        end
        serial_data = ~w[0]; // No stale bit
        #40 load_strobe = 1'b1;
        #100 load_strobe = 1'b0;
        #60;
    endtask
endmodule // dsl_host_model

// File: test/dsl_serial_latch_bank_assertions.sv
`timescale 1ns/1ps
module dsl_serial_latch_bank_assertions
    import dsl_pkg::*;
#(
    parameter int WIDE_DIV = 0
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic ref_clock_in,
    input wire logic [1:0] feedback_in,
    input wire dsl_chan_cfg_type [1:0] chan_cfg,
    input wire logic [1:0] modulus_control,
    input wire logic [1:0] pump_up,
    input wire logic [1:0] pump_down,
    input wire logic [1:0] pump_tristate,
    input wire logic [1:0] powered_down,
    input wire logic multiplexed_status_output,
    input wire logic multiplexed_status_output_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Latch bits per channel
    wire logic [1:0] tri_bit = {chan_cfg[1].pump_tristate, chan_cfg[0].pump_tristate};
    wire logic [1:0] pd_bit = {chan_cfg[1].powerdown_bit, chan_cfg[0].powerdown_bit};
    wire logic [3:0] mux_sel = {chan_cfg[1].out_select_high, chan_cfg[1].out_select_low,
        chan_cfg[0].out_select_high, chan_cfg[0].out_select_low};
    wire logic is_lock = (mux_sel == MUX_IF_LOCK) || (mux_sel == MUX_RF_LOCK)
        || (mux_sel == MUX_BOTH_LOCK);

    sequence s_lock_sel;
        is_lock ##1 is_lock;
    endsequence
    sequence s_low_sel;
        (mux_sel == MUX_LOW) ##1 (mux_sel == MUX_LOW);
    endsequence

    property p_cfg_cause;
        $changed(chan_cfg) |->
            $past(load_strobe, 3) || $past(load_strobe, 4) || $past(load_strobe, 5);
    endproperty
    a_cfg_cause: assert property (p_cfg_cause)
        else $error("latch changed without a load strobe");
    property p_tri_bit;
        (tri_bit & ~pump_tristate) == 2'h0;
    endproperty
    a_tri_bit: assert property (p_tri_bit)
        else $error("tristate bit set but pump driven");
    property p_quiet;
        ((pump_up | pump_down) & pump_tristate) == 2'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pump pulse while three-stated");
    property p_pd_async;
        (pd_bit & tri_bit & ~$past(pd_bit) & ~powered_down) == 2'h0;
    endproperty
    a_pd_async: assert property (p_pd_async)
        else $error("power-down late with tristate set");
    property p_pd_tri;
        ((pd_bit | powered_down) & ~pump_tristate) == 2'h0;
    endproperty
    a_pd_tri: assert property (p_pd_tri)
        else $error("power-down without three-state");
    property p_pd_order;
        (powered_down & ~$past(powered_down) & ~$past(pump_tristate)) == 2'h0;
    endproperty
    a_pd_order: assert property (p_pd_order)
        else $error("powered down before pump three-stated");
    property p_pd_clear;
        (~pd_bit & ~$past(pd_bit) & powered_down) == 2'h0;
    endproperty
    a_pd_clear: assert property (p_pd_clear)
        else $error("power-down held with bit clear");
    property p_lock_od;
        s_lock_sel |-> !multiplexed_status_output;
    endproperty
    a_lock_od: assert property (p_lock_od)
        else $error("lock mode output not open-drain");
    property p_mux_low;
        s_low_sel |-> !multiplexed_status_output && multiplexed_status_output_oe;
    endproperty
    a_mux_low: assert property (p_mux_low)
        else $error("status output not driven low");
endmodule // dsl_serial_latch_bank_assertions

bind dsl_serial_latch_bank dsl_serial_latch_bank_assertions #(.WIDE_DIV(WIDE_DIV)) u_chk (
    .clk(clk), .rstn(rstn), .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe), .ref_clock_in(ref_clock_in), .feedback_in(feedback_in),
    .chan_cfg(chan_cfg), .modulus_control(modulus_control), .pump_up(pump_up),
    .pump_down(pump_down), .pump_tristate(pump_tristate), .powered_down(powered_down),
    .multiplexed_status_output(multiplexed_status_output),
    .multiplexed_status_output_oe(multiplexed_status_output_oe));

// File: test/tb_dual_synth_serial_latch_bank.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_dual_synth_serial_latch_bank
    import dsl_pkg::*;
;
    logic clk, rstn, ref_clock_in, serial_clock, serial_data, load_strobe, mux_out, mux_oe;
    logic [1:0] feedback_in, modulus_control, pump_up, pump_down, pump_tristate, powered_down;
    dsl_chan_cfg_type [1:0] chan_cfg;
    logic [21:0] lat [4];
    logic [31:0] seed;
    int error_cnt, num_checks, cyc;
    logic [7:0] pulses;
    logic corr;
    localparam logic [21:0] PD_SEQ [6] = '{22'h080000, 22'h200001, 22'h000001,
        22'h000000, 22'h200001, 22'h000001};

    dsl_host_model u_dsl_host_model (.serial_clock(serial_clock),
        .serial_data(serial_data), .load_strobe(load_strobe));
    dsl_serial_latch_bank #(.WIDE_DIV(0)) u_dsl_serial_latch_bank (.clk(clk), .rstn(rstn),
        .serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe),
        .ref_clock_in(ref_clock_in), .feedback_in(feedback_in), .chan_cfg(chan_cfg),
        .modulus_control(modulus_control), .pump_up(pump_up), .pump_down(pump_down),
        .pump_tristate(pump_tristate), .powered_down(powered_down),
        .multiplexed_status_output(mux_out), .multiplexed_status_output_oe(mux_oe));

    // ----
    // Expectations
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [37:0] exp_f(input logic [21:0] r, input logic [21:0] a);
        return {r[15:2], r[17], r[18], r[19], r[20], r[21], a[19:9], a[7:2], a[20], a[21]};
    endfunction
    function automatic logic [37:0] got_f(input dsl_chan_cfg_type c);
        return {c.ref_div[13:0], c.polarity, c.pump_gain, c.pump_tristate,
            c.out_select_low, c.out_select_high, c.main_count[10:0], c.swallow_count,
            c.prescaler_select, c.powerdown_bit};
    endfunction

    // Send one word and check every latch effect
    task automatic put(input logic [21:0] w);
        logic [3:0] code;
        u_dsl_host_model.send(w);
        lat[w[1:0]] = w;
        repeat (3) @(negedge clk);
        code = {lat[2][21:20], lat[0][21:20]};
        for (int c = 0; c < 2; c++)
        begin
            `CHK(got_f(chan_cfg[c]), exp_f(lat[2 * c], lat[2 * c + 1]))
            `CHK({chan_cfg[c].ref_div[14], chan_cfg[c].main_count[12:11]}, 3'h0)
        end
        `CHK(powered_down, {lat[3][21], lat[1][21]})
        `CHK(pump_tristate, {lat[2][19] | lat[3][21], lat[0][19] | lat[1][21]})
        // Reference and feedback idle here: no lock, no status pulse
        if (code inside {MUX_IF_LOCK, MUX_RF_LOCK, MUX_BOTH_LOCK})
            `CHK({mux_out, mux_oe}, 2'b01)
        else
            `CHK({mux_out, mux_oe}, 2'b01)
    endtask

    // Reference rises, IF feedback alongside if asked; counts status pulses
    task automatic tick(input int n, input logic fb);
        for (int i = 0; i < 2 * n; i++)
        begin
            ref_clock_in = ~ref_clock_in;
            if (fb)
                feedback_in[0] = ref_clock_in;
            repeat (4)
            begin
                @(negedge clk);
                pulses += {7'h00, mux_out};
                corr |= pump_up[0] | pump_down[0];
            end
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cycle ceiling
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // Main sequence
    initial
    begin
        rstn = 1'b0;
        ref_clock_in = 1'b0;
        feedback_in = 2'h0;
        seed = 32'h3db83a1f;
        foreach (lat[i]) lat[i] = 22'h0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        // Power-down both ways, each channel
        for (int c = 0; c < 2; c++)
        begin
            foreach (PD_SEQ[k]) put(PD_SEQ[k] | {20'h0, c[0], 1'b0});
        end
        // Corners, then random words over all selectors
        for (int i = 0; i < 18; i++)
        begin
            repeat (7) seed = lfsr(seed);
            put(i == 0 ? 22'h3fffff : i == 1 ? 22'h100000 : {seed[21:2], i[1:0]});
        end
        // IF dividers, comparator and lock detect
        put(22'h080002); // RF pump three-stated, no RF status source
        put(22'h120008); // IF R of 2, positive polarity, IF lock source
        put(22'h200405); // IF power-down reloads B of 2, A of 1
        put(22'h000405);
        `CHK(modulus_control[0], 1'b1)
        pulses = 8'h00;
        corr = 1'b0;
        tick(1, 1'b1);
        `CHK(modulus_control[0], 1'b0)
        tick(33, 1'b1);
        `CHK(corr, 1'b0)
        `CHK({mux_out, mux_oe}, 2'b00)
        // Reference leads: up pulse holds, lock lost
        tick(2, 1'b0);
        `CHK({pump_up[0], pump_down[0]}, 2'b10)
        `CHK({mux_out, mux_oe}, 2'b01)
        // IF R of 3, negative polarity, reference pulses on status
        put(22'h20000c);
        pulses = 8'h00;
        tick(12, 1'b0);
        `CHK(pulses, 8'h04)
        `CHK({pump_up[0], pump_down[0]}, 2'b01)
        complete_run();
    end
endmodule // tb_dual_synth_serial_latch_bank
